// >>> verilog/data_move_cfg.svh
// constants for the data-move instruction unit
`ifndef DATA_MOVE_CFG_SVH
`define DATA_MOVE_CFG_SVH
`define DM_OPC_MASK_LIT      14'h3F00
`define DM_OPC_LIT_ACC       14'h3000
`define DM_OPC_MASK_BSR      14'h3FE0
`define DM_OPC_BSR           14'h0020
`define DM_OPC_MASK_PAGE     14'h3F80
`define DM_OPC_PAGE          14'h3180
`define DM_OPC_MASK_ACCF     14'h3F80
`define DM_OPC_ACCF          14'h0080
`define DM_OPC_MASK_IND      14'h3FF8
`define DM_OPC_IND           14'h0010
`define DM_OPC_MASK_REL      14'h3F80
`define DM_OPC_REL           14'h3F00
`define DM_IND_SEL_BIT       2
`define DM_REL_SEL_BIT       6
`define DM_PTR_RESET         16'h0000
`define DM_ACC_RESET         8'h00
`define DM_BSR_RESET         5'h00
`define DM_PAGE_RESET        7'h00
`define DM_PTR_ONE           16'h0001
`define DM_MODE_PRE_INC      2'h0
`define DM_MODE_PRE_DEC      2'h1
`define DM_MODE_POST_INC     2'h2
`define DM_MODE_POST_DEC     2'h3
`define DM_LIT_ACC_DONT_CARE 14'h0000
`define DM_MODE_MSB          1
`define DM_MODE_LSB          0
`define DM_LIT_LSB           0
`define DM_LIT5_MSB          4
`define DM_LIT7_MSB          6
`define DM_LIT8_MSB          7
`define DM_FADDR_MSB         6
`define DM_OFS_MSB           5
`define DM_OFS_EXT           10
`define DM_FADDR_PAD         9'h000
`define DM_ZERO_BYTE         8'h00
`define DM_FLAG_RESET        1'h0
`endif

// >>> verilog/data_move_pkg.sv
// types for the data-move instruction unit
package data_move_pkg;
    // data memory access request toward the register file
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        ind;
    } mem_req_type;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_IND,
        OP_REL,
        OP_BSR,
        OP_PAGE,
        OP_LIT,
        OP_ACCF
    } op_type;

    // all state of the unit
    typedef struct packed {
        logic [15:0] ptr0;
        logic [15:0] ptr1;
        logic [7:0]  acc;
        logic [4:0]  bank_select_register;
        logic [6:0]  page;
        logic        zero;
        logic        zero_we;
    } state_type;
endpackage

// >>> verilog/data_move_instruction_unit.sv
// decode and execute for the data-move instruction group
`timescale 1ns/1ps
`include "data_move_cfg.svh"

module data_move_instruction_unit (
    input  wire logic                       i_mclk,
    input  wire logic                       i_reset_n,
    input  wire logic                       i_valid,
    input  wire logic [13:0]                i_instr,
    input  wire logic [7:0]                 i_rdata,
    output data_move_pkg::mem_req_type      o_mem,
    output logic [15:0]                     o_ptr0,
    output logic [15:0]                     o_ptr1,
    output logic [7:0]                      o_acc,
    output logic [4:0]                      o_bank_select,
    output logic [6:0]                      o_pc_high_latch,
    output logic                            o_zero,
    output logic                            o_zero_we
);
    data_move_pkg::state_type s_q;
    data_move_pkg::state_type s_d;
    data_move_pkg::op_type    op;
    data_move_pkg::mem_req_type mem;
    logic        hit_ind;   // mode form of the indirect move
    logic        hit_rel;   // offset form of the indirect move
    logic        hit_bsr;
    logic        hit_page;
    logic        hit_lit;
    logic        hit_accf;
    logic        sel;       // pointer named by the instruction
    logic [1:0]  mode;      // pre/post and increment/decrement
    logic [4:0]  lit5;      // bank select literal
    logic [6:0]  lit7;      // page latch literal
    logic [7:0]  lit8;      // accumulator literal
    logic [6:0]  faddr;     // file register address
    logic [15:0] ptr;       // value of the named pointer
    logic [15:0] ptr_inc;
    logic [15:0] ptr_dec;
    logic [15:0] ptr_new;   // pointer value after the move
    logic [15:0] offset;    // sign-extended relative offset
    logic        ptr0_we;
    logic        ptr1_we;

    // raw opcode matches; the six groups never overlap
    always_comb begin
        hit_rel  = (i_instr & `DM_OPC_MASK_REL) == `DM_OPC_REL;
        hit_lit  = (i_instr & `DM_OPC_MASK_LIT)
                   == (`DM_OPC_LIT_ACC | `DM_LIT_ACC_DONT_CARE);
        hit_page = (i_instr & `DM_OPC_MASK_PAGE) == `DM_OPC_PAGE;
        hit_bsr  = (i_instr & `DM_OPC_MASK_BSR) == `DM_OPC_BSR;
        hit_accf = (i_instr & `DM_OPC_MASK_ACCF) == `DM_OPC_ACCF;
        hit_ind  = (i_instr & `DM_OPC_MASK_IND) == `DM_OPC_IND;
    end

    // opcode decode; a word in no group is refused and does nothing
    always_comb begin
        op = data_move_pkg::OP_NONE;
        if (!i_valid) begin
            op = data_move_pkg::OP_NONE;
        end else if (hit_rel) begin
            op = data_move_pkg::OP_REL;
        end else if (hit_lit) begin
            op = data_move_pkg::OP_LIT;
        end else if (hit_page) begin
            op = data_move_pkg::OP_PAGE;
        end else if (hit_bsr) begin
            op = data_move_pkg::OP_BSR;
        end else if (hit_accf) begin
            op = data_move_pkg::OP_ACCF;
        end else if (hit_ind) begin
            op = data_move_pkg::OP_IND;
        end
    end

    // operand fields of the instruction word
    always_comb begin
        mode   = i_instr[`DM_MODE_MSB:`DM_MODE_LSB];
        lit5   = i_instr[`DM_LIT5_MSB:`DM_LIT_LSB];
        lit7   = i_instr[`DM_LIT7_MSB:`DM_LIT_LSB];
        lit8   = i_instr[`DM_LIT8_MSB:`DM_LIT_LSB];
        faddr  = i_instr[`DM_FADDR_MSB:`DM_LIT_LSB];
        offset = {{`DM_OFS_EXT{i_instr[`DM_OFS_MSB]}},
                  i_instr[`DM_OFS_MSB:`DM_LIT_LSB]};
    end

    // pointer select and arithmetic, 16-bit wrap
    always_comb begin
        sel = (op == data_move_pkg::OP_REL) ? i_instr[`DM_REL_SEL_BIT]
                                            : i_instr[`DM_IND_SEL_BIT];
        ptr     = sel ? s_q.ptr1 : s_q.ptr0;
        ptr_inc = ptr + `DM_PTR_ONE;
        ptr_dec = ptr - `DM_PTR_ONE;
    end

    // only the mode form moves a pointer; the offset form keeps both
    always_comb begin
        ptr0_we = (op == data_move_pkg::OP_IND) && !sel;
        ptr1_we = (op == data_move_pkg::OP_IND) && sel;
    end

    // memory request; the window itself has no storage behind it
    always_comb begin
        mem       = '0;
        ptr_new   = ptr;
        case (op)
            // mode form: address and new pointer from the two-bit field
            data_move_pkg::OP_IND: begin
                mem.rd  = 1'h1;
                mem.ind = 1'h1;
                case (mode)
                    // step first, then read at the stepped address
                    `DM_MODE_PRE_INC: begin
                        mem.addr = ptr_inc;
                        ptr_new  = ptr_inc;
                    end
                    `DM_MODE_PRE_DEC: begin
                        mem.addr = ptr_dec;
                        ptr_new  = ptr_dec;
                    end
                    // read at the old address, then step
                    `DM_MODE_POST_INC: begin
                        mem.addr = ptr;
                        ptr_new  = ptr_inc;
                    end
                    default: begin
                        mem.addr = ptr;
                        ptr_new  = ptr_dec;
                    end
                endcase
            end
            // offset form: read only, pointer not written back
            data_move_pkg::OP_REL: begin
                mem.rd   = 1'h1;
                mem.ind  = 1'h1;
                mem.addr = ptr + offset;
            end
            // plain file write of the accumulator, bank not appended
            data_move_pkg::OP_ACCF: begin
                mem.wr    = 1'h1;
                mem.addr  = {`DM_FADDR_PAD, faddr};
                mem.wdata = s_q.acc;
            end
            default: begin
                mem = '0;
            end
        endcase
    end

    // next state, every instruction finishes in the cycle it is presented
    always_comb begin
        s_d         = s_q;
        s_d.zero_we = 1'h0;
        case (op)
            // both indirect forms load the accumulator and the zero flag
            data_move_pkg::OP_IND, data_move_pkg::OP_REL: begin
                s_d.acc     = i_rdata;
                s_d.zero    = (i_rdata == `DM_ZERO_BYTE);
                s_d.zero_we = 1'h1;
            end
            // literal loads touch no flag
            data_move_pkg::OP_BSR: begin
                s_d.bank_select_register = lit5;
            end
            data_move_pkg::OP_PAGE: begin
                s_d.page = lit7;
            end
            data_move_pkg::OP_LIT: begin
                s_d.acc = lit8;
            end
            // file write and refused words leave the state alone
            default: begin
                s_d.zero_we = 1'h0;
            end
        endcase
        // pointer write-back after the move, 16-bit wrap
        if (ptr0_we) begin
            s_d.ptr0 = ptr_new;
        end
        if (ptr1_we) begin
            s_d.ptr1 = ptr_new;
        end
    end

    // state register
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            s_q.ptr0    <= `DM_PTR_RESET;
            s_q.ptr1    <= `DM_PTR_RESET;
            s_q.acc     <= `DM_ACC_RESET;
            s_q.bank_select_register     <= `DM_BSR_RESET;
            s_q.page    <= `DM_PAGE_RESET;
            s_q.zero    <= `DM_FLAG_RESET;
            s_q.zero_we <= `DM_FLAG_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // memory request straight from the decode, same cycle
    assign o_mem           = mem;

    // pointers and accumulator, one cycle after the instruction
    assign o_ptr0          = s_q.ptr0;
    assign o_ptr1          = s_q.ptr1;
    assign o_acc           = s_q.acc;

    // bank and page latches
    assign o_bank_select   = s_q.bank_select_register;
    assign o_pc_high_latch = s_q.page;

    // zero flag and its one-cycle write strobe
    assign o_zero          = s_q.zero;
    assign o_zero_we       = s_q.zero_we;
endmodule

// >>> verification/data_move_props.sv
// assertion checker for the data-move instruction unit
`timescale 1ns/1ps
module data_move_props (
    input wire logic                  i_mclk,
    input wire logic                  i_reset_n,
    input wire logic                  i_valid,
    input wire logic [13:0]           i_instr,
    input wire logic [7:0]            i_rdata,
    input data_move_pkg::mem_req_type o_mem,
    input wire logic [15:0]           o_ptr0,
    input wire logic [15:0]           o_ptr1,
    input wire logic [7:0]            o_acc,
    input wire logic [4:0]            o_bank_select,
    input wire logic [6:0]            o_pc_high_latch,
    input wire logic                  o_zero,
    input wire logic                  o_zero_we
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);
    // decode of the two indirect forms and their selected pointer
    logic        ind;
    logic        rel;
    logic [15:0] pi;
    logic [15:0] pr;
    assign ind = i_valid && i_instr[13:3] == 11'h002;
    assign rel = i_valid && i_instr[13:7] == 7'h7E;
    assign pi = i_instr[2] ? o_ptr1 : o_ptr0;
    assign pr = i_instr[6] ? o_ptr1 : o_ptr0;
    ind_addr_a: assert property (ind |-> o_mem.rd && o_mem.ind && o_mem.addr ==
        (i_instr[1] ? pi : i_instr[0] ? pi - 16'h0001 : pi + 16'h0001)) else $error("ind addr");
    ind_ptr_a: assert property (ind && !i_instr[2] |=> $stable(o_ptr1) &&
        o_ptr0 == $past(o_ptr0) + ($past(i_instr[0]) ? 16'hFFFF : 16'h0001)) else $error("ptr");
    ind_ptr1_a: assert property (ind && i_instr[2] |=> $stable(o_ptr0) &&
        o_ptr1 == $past(o_ptr1) + ($past(i_instr[0]) ? 16'hFFFF : 16'h0001)) else $error("ptr1");
    ind_zero_a: assert property (ind || rel |=> o_zero_we && o_acc == $past(i_rdata) &&
        o_zero == ($past(i_rdata) == 8'h00)) else $error("ind acc or zero");
    rel_addr_a: assert property (rel |-> o_mem.rd && o_mem.addr == pr +
        {{10{i_instr[5]}}, i_instr[5:0]} ##1 $stable(o_ptr0) && $stable(o_ptr1)) else $error("rel");
    lit_load_a: assert property (i_valid && i_instr[13:8] == 6'h30 |=>
        o_acc == $past(i_instr[7:0]) && !o_zero_we && $stable(o_zero)) else $error("lit");
    bank_load_a: assert property (i_valid && i_instr[13:5] == 9'h001 |=>
        o_bank_select == $past(i_instr[4:0]) && $stable(o_zero)) else $error("bank");
    page_load_a: assert property (i_valid && i_instr[13:7] == 7'h63 |=>
        o_pc_high_latch == $past(i_instr[6:0]) && $stable(o_zero)) else $error("page");
    acc_file_a: assert property (i_valid && i_instr[13:7] == 7'h01 |-> o_mem.wr &&
        o_mem.addr == {9'h000, i_instr[6:0]} && o_mem.wdata == o_acc ##1 $stable(o_acc))
        else $error("acc to file");
endmodule
bind data_move_instruction_unit data_move_props props (
    .i_mclk          (i_mclk),
    .i_reset_n       (i_reset_n),
    .i_valid         (i_valid),
    .i_instr         (i_instr),
    .i_rdata         (i_rdata),
    .o_mem           (o_mem),
    .o_ptr0          (o_ptr0),
    .o_ptr1          (o_ptr1),
    .o_acc           (o_acc),
    .o_bank_select   (o_bank_select),
    .o_pc_high_latch (o_pc_high_latch),
    .o_zero          (o_zero),
    .o_zero_we       (o_zero_we)
);

// >>> verification/tb_data_move_instruction_unit.sv
// self-checking bench for the data-move instruction unit
`timescale 1ns/1ps
module tb_data_move_instruction_unit;
    logic                       i_mclk;
    logic                       i_reset_n;
    logic                       i_valid;
    logic [13:0]                i_instr;
    logic [7:0]                 i_rdata;
    data_move_pkg::mem_req_type o_mem;
    data_move_pkg::mem_req_type m;
    logic [15:0]                o_ptr0, o_ptr1, e0, e1, ea;
    logic [7:0]                 o_acc;
    logic [4:0]                 o_bank_select;
    logic [6:0]                 o_pc_high_latch;
    logic                       o_zero, o_zero_we;
    int                         n_mismatch = 0, compares = 0, cyc = 0;
    data_move_instruction_unit dut (
        .i_mclk          (i_mclk),
        .i_reset_n       (i_reset_n),
        .i_valid         (i_valid),
        .i_instr         (i_instr),
        .i_rdata         (i_rdata),
        .o_mem           (o_mem),
        .o_ptr0          (o_ptr0),
        .o_ptr1          (o_ptr1),
        .o_acc           (o_acc),
        .o_bank_select   (o_bank_select),
        .o_pc_high_latch (o_pc_high_latch),
        .o_zero          (o_zero),
        .o_zero_we       (o_zero_we)
    );
    task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one instruction, memory request captured, registers settled
    task automatic op(logic [13:0] w, logic [7:0] rd);
        @(posedge i_mclk);
        i_valid <= 1'b1;
        i_instr <= w;
        i_rdata <= rd;
        #1 m = o_mem;
        @(posedge i_mclk);
        i_valid <= 1'b0;
        #1;
    endtask
    task automatic t_lit();
        op(14'h30A5, 8'h00);
        chk("acc", 16'h00A5, o_acc);
        chk("zero_we", 16'h0000, o_zero_we);
        op(14'h00FF, 8'h00);
        chk("wr", 16'h0001, m.wr);
        chk("find", 16'h0000, m.ind);
        chk("faddr", 16'h007F, m.addr);
        chk("fdata", 16'h00A5, m.wdata);
        chk("acc_kept", 16'h00A5, o_acc);
        $display("test literal done");
    endtask
    // every mode on both pointers, starting at the wrap points
    task automatic t_ind();
        logic [1:0] md;
        for (int i = 0; i < 8; i++) begin
            md = i[1:0] ^ 2'h1;
            ea = i[2] ? e1 : e0;
            ea = md[1] ? ea : (md[0] ? ea - 16'h0001 : ea + 16'h0001);
            if (i[2]) e1 = md[0] ? e1 - 16'h0001 : e1 + 16'h0001;
            else e0 = md[0] ? e0 - 16'h0001 : e0 + 16'h0001;
            op(14'h0010 | {11'h000, i[2], md}, 8'(i));
            chk("iaddr", ea, m.addr);
            chk("ind", 16'h0001, m.ind);
            chk("ird", 16'h0001, m.rd);
            chk("iacc", 16'(i), o_acc);
            chk("zero", 16'(i == 0), o_zero);
            chk("zwe", 16'h0001, o_zero_we);
            chk("ptr0", e0, o_ptr0);
            chk("ptr1", e1, o_ptr1);
        end
        $display("test indirect done");
    endtask
    task automatic t_rel();
        op(14'h3F60, 8'h80);
        chk("rneg", e1 - 16'h0020, m.addr);
        op(14'h3F5F, 8'h00);
        chk("rpos", e1 + 16'h001F, m.addr);
        chk("rptr", e1, o_ptr1);
        chk("rzero", 16'h0001, o_zero);
        $display("test offset done");
    endtask
    task automatic t_bank();
        op(14'h003F, 8'h00);
        chk("bank", 16'h001F, o_bank_select);
        op(14'h31FF, 8'h00);
        chk("page", 16'h007F, o_pc_high_latch);
        chk("zkept", 16'h0001, o_zero);
        $display("test bank and page done");
    endtask
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // clock and watchdog
    initial begin
        i_mclk = 1'b0;
        forever #2.5 i_mclk = ~i_mclk;
    end
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 500) begin
            n_mismatch++;
            wrap_up();
        end
    end
    initial begin
        i_reset_n = 1'b0;
        i_valid = 1'b0;
        i_instr = 14'h0000;
        i_rdata = 8'h00;
        e0 = 16'h0000;
        e1 = 16'h0000;
        repeat (8) @(posedge i_mclk);
        i_reset_n <= 1'b1;
        t_lit();
        t_ind();
        t_rel();
        t_bank();
        wrap_up();
    end
endmodule
